// file: verilog/fbmon_pkg.sv
`default_nettype none
package fbmon_pkg;

    // ========================================
    // Bus request encodings
    localparam logic [7:0] FUNC_READ_HOLDING  = 8'h03;
    localparam logic [7:0] FUNC_WRITE_SINGLE  = 8'h06;

    localparam logic [7:0] EXC_NONE           = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNC   = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR   = 8'h02;
    localparam logic [7:0] EXC_DEVICE_FAIL    = 8'h04;

    localparam logic [15:0] REG_NUM_BASE      = 16'h0001;

    // ========================================
    // Monitoring register numbers
    localparam logic [15:0] REG_STATUS        = 16'h0006;
    localparam logic [15:0] REG_FREQ          = 16'h0007;
    localparam logic [15:0] REG_AMPS          = 16'h0008;
    localparam logic [15:0] REG_TORQUE        = 16'h0009;
    localparam logic [15:0] REG_KW            = 16'h000a;
    localparam logic [15:0] REG_DIN           = 16'h000b;
    localparam logic [15:0] REG_ANALOG1       = 16'h0014;
    localparam logic [15:0] REG_ANALOG2       = 16'h0015;
    localparam logic [15:0] REG_SETPOINT      = 16'h0016;
    localparam logic [15:0] REG_DC_VOLTS      = 16'h0017;
    localparam logic [15:0] REG_HEATSINK      = 16'h0018;

    // ========================================
    // Status byte field positions
    localparam int STS_RUNNING  = 0;
    localparam int STS_TRIPPED  = 1;
    localparam int STS_STO_OPEN = 3;
    localparam int STS_MAINT    = 4;
    localparam int STS_STANDBY  = 5;
    localparam int STS_READY    = 6;
    localparam logic [7:0] STS_RESET = 8'h00;
    localparam logic [7:0] FAULT_NONE = 8'h00;

    // ========================================
    // Parameter window
    localparam logic [15:0] PARAM_STRIDE      = 16'h0064;
    localparam logic [15:0] PARAM_GROUP_FIRST = 16'h0001;
    localparam logic [15:0] PARAM_GROUP_LAST  = 16'h0005;
    localparam logic [15:0] PARAM_IDX_FIRST   = 16'h0001;
    localparam logic [15:0] PARAM_IDX_LAST    = 16'h003f;
    localparam int          PARAM_IDX_BITS    = 6;
    localparam int          PARAM_SLOT_BITS   = 9;
    localparam int          PARAM_DEPTH       = 320;
    localparam logic [15:0] PARAM_RESET       = 16'h0000;

    // Parameters that steer the serial link itself, then the ones locked while running
    localparam logic [15:0] fieldbus_node_address_param = 16'h01f5;
    localparam logic [15:0] serial_baud_param           = 16'h01f7;
    localparam logic [15:0] serial_frame_format_param   = 16'h01f8;
    localparam logic [15:0] serial_node_address_param   = 16'h0204;
    localparam logic [15:0] command_source_select_param = 16'h0070;
    localparam logic [15:0] LOCKED_GROUP                = 16'h0005;

endpackage
`default_nettype wire

// file: verilog/param_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface param_mem_if;
    logic                                we;
    logic [fbmon_pkg::PARAM_SLOT_BITS-1:0] waddr;
    logic [15:0]                         wdata;
    logic [fbmon_pkg::PARAM_SLOT_BITS-1:0] raddr;
    logic [15:0]                         rdata;

    modport store (input we, input waddr, input wdata, input raddr, output rdata);
    modport user  (output we, output waddr, output wdata, output raddr, input rdata);
endinterface
`default_nettype wire

// file: verilog/param_store.sv
`timescale 1ns/1ps
`default_nettype none
module param_store (
    input  wire logic     clk,
    input  wire logic     rst_n,
    input  wire logic     ce,
    param_mem_if.store    mem
);

    logic [15:0] words_q [fbmon_pkg::PARAM_DEPTH];
    logic [15:0] rdata_q;

    // ========================================
    // Storage, cleared so reads before any write are defined
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < fbmon_pkg::PARAM_DEPTH; i++) begin
                words_q[i] <= fbmon_pkg::PARAM_RESET;
            end
        end else if (ce && mem.we) begin
            words_q[mem.waddr] <= mem.wdata;
        end
    end

    // ========================================
    // Registered read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= fbmon_pkg::PARAM_RESET;
        end else if (ce) begin
            rdata_q <= words_q[mem.raddr];
        end
    end

    assign mem.rdata = rdata_q;

endmodule
`default_nettype wire

// file: verilog/fieldbus_monitor_register_map.sv
// Overview of operation
// - Status bit 5 shows standby active
// - Status bit 6: mains, no inhibit, no trip, enabled
// - Status bit 7 unused, reads zero
// - Upper byte holds fault code on trip
// - Register 7: output frequency, tenths hertz
// - Register 8: output current, tenths ampere
// - Register 9: torque, tenths percent
// - Register 10: power, hundredths kilowatt
// - Register 11: digital inputs, bit 0 first
// - Registers 20, 21: analog levels, tenths percent
// - Register 22: setpoint before ramp
// - Register 23: DC bus whole volts
// - Register 24: heatsink whole degrees Celsius
// - Groups 1 to 5 parameters read/write
// - Address, baud, format parameters excluded
// - Some parameters locked while drive running
// - Register number is group*100 plus index
// - Values are 16-bit, decimals scaled ten, power scaled a hundred
// - Low byte: run, trip, inhibit, maintenance flags
// - Function 03 reads, 06 writes
`timescale 1ns/1ps
`default_nettype none
module fieldbus_monitor_register_map (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        req_valid,
    input  wire logic [7:0]  req_func,
    input  wire logic [15:0] req_addr,
    input  wire logic [15:0] req_wdata,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic [7:0]       rsp_exc,
    input  wire logic        drive_running,
    input  wire logic        drive_tripped,
    input  wire logic        sto_open,
    input  wire logic        maint_due,
    input  wire logic        standby_active,
    input  wire logic        mains_present,
    input  wire logic        enable_pin,
    input  wire logic [7:0]  fault_code,
    input  wire logic [15:0] output_freq_tenths_hz,
    input  wire logic [15:0] output_amps_tenths,
    input  wire logic [15:0] motor_torque_tenths_pct,
    input  wire logic [15:0] output_kw_hundredths,
    input  wire logic [15:0] din_pins,
    input  wire logic [15:0] analog_in_one_level,
    input  wire logic [15:0] analog_in_two_level,
    input  wire logic [15:0] unramped_freq_setpoint,
    input  wire logic [15:0] dc_link_volts,
    input  wire logic [15:0] heatsink_celsius
);

    // ========================================
    // Functions
    function automatic logic [15:0] group_of(input logic [15:0] num);
        group_of = num / fbmon_pkg::PARAM_STRIDE;
    endfunction

    function automatic logic [15:0] index_of(input logic [15:0] num);
        index_of = num % fbmon_pkg::PARAM_STRIDE;
    endfunction

    function automatic logic is_param(input logic [15:0] num);
        is_param = (group_of(num) >= fbmon_pkg::PARAM_GROUP_FIRST)
                && (group_of(num) <= fbmon_pkg::PARAM_GROUP_LAST)
                && (index_of(num) >= fbmon_pkg::PARAM_IDX_FIRST)
                && (index_of(num) <= fbmon_pkg::PARAM_IDX_LAST);
    endfunction

    // Index 1 to 63 fits six bits, so each group packs into a 64-word page
    function automatic logic [fbmon_pkg::PARAM_SLOT_BITS-1:0] slot_of(input logic [15:0] num);
        logic [15:0] g;
        logic [15:0] s;
        g = group_of(num) - fbmon_pkg::PARAM_GROUP_FIRST;
        s = (g << fbmon_pkg::PARAM_IDX_BITS) | index_of(num);
        slot_of = s[fbmon_pkg::PARAM_SLOT_BITS-1:0];
    endfunction

    // ========================================
    // Reset release
    // Release is re-timed so no flop leaves reset on a ragged edge
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else if (ce) begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ========================================
    // Pin synchronisers
    logic [15:0] din_meta_q;
    logic [15:0] din_sync_q;
    logic        en_meta_q;
    logic        en_sync_q;

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            din_meta_q <= 16'h0000;
            din_sync_q <= 16'h0000;
        end else if (ce) begin
            din_meta_q <= din_pins;
            din_sync_q <= din_meta_q;
        end
    end

    // Enable pin is asynchronous to the drive logic
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            en_meta_q <= 1'b0;
            en_sync_q <= 1'b0;
        end else if (ce) begin
            en_meta_q <= enable_pin;
            en_sync_q <= en_meta_q;
        end
    end

    // ========================================
    // Status word
    logic [7:0]  status_byte;
    logic [7:0]  fault_byte;
    logic [15:0] status_word;

    // Status levels come from logic on this clock, so no re-timing
    always_comb begin
        status_byte = fbmon_pkg::STS_RESET;
        status_byte[fbmon_pkg::STS_RUNNING]  = drive_running;
        status_byte[fbmon_pkg::STS_TRIPPED]  = drive_tripped;
        status_byte[fbmon_pkg::STS_STO_OPEN] = sto_open;
        status_byte[fbmon_pkg::STS_MAINT]    = maint_due;
        status_byte[fbmon_pkg::STS_STANDBY]  = standby_active;
        // Ready follows the pin two edges late, like the input bits
        // Ready needs all four
        status_byte[fbmon_pkg::STS_READY]    = mains_present && !sto_open
                                               && !drive_tripped && en_sync_q;
        // Bit seven stays zero from STS_RESET
        fault_byte  = drive_tripped ? fault_code : fbmon_pkg::FAULT_NONE;
        status_word = {fault_byte, status_byte};
    end

    // ========================================
    // Request decode
    logic [15:0] reg_num;
    logic        is_write;
    logic        param_hit;
    logic        excluded;
    logic        locked;
    logic        mon_hit;
    logic [15:0] mon_d;
    logic [7:0]  exc_d;
    logic        use_mem_d;

    // Wire address is number minus one
    assign reg_num = req_addr + fbmon_pkg::REG_NUM_BASE;

    // Registers 1 to 4 belong to the control block and answer as unknown
    always_comb begin
        mon_hit = 1'b1;
        mon_d   = 16'h0000;
        if (reg_num == fbmon_pkg::REG_STATUS) begin
            mon_d = status_word;
        end else if (reg_num == fbmon_pkg::REG_FREQ) begin
            mon_d = output_freq_tenths_hz;
        end else if (reg_num == fbmon_pkg::REG_AMPS) begin
            mon_d = output_amps_tenths;
        end else if (reg_num == fbmon_pkg::REG_TORQUE) begin
            mon_d = motor_torque_tenths_pct;
        end else if (reg_num == fbmon_pkg::REG_KW) begin
            mon_d = output_kw_hundredths;
        end else if (reg_num == fbmon_pkg::REG_DIN) begin
            mon_d = din_sync_q;
        end else if (reg_num == fbmon_pkg::REG_ANALOG1) begin
            mon_d = analog_in_one_level;
        end else if (reg_num == fbmon_pkg::REG_ANALOG2) begin
            mon_d = analog_in_two_level;
        end else if (reg_num == fbmon_pkg::REG_SETPOINT) begin
            mon_d = unramped_freq_setpoint;
        end else if (reg_num == fbmon_pkg::REG_DC_VOLTS) begin
            mon_d = dc_link_volts;
        end else if (reg_num == fbmon_pkg::REG_HEATSINK) begin
            mon_d = heatsink_celsius;
        end else begin
            mon_hit = 1'b0;
        end
    end

    // One register per request; the frame layer splits longer reads
    always_comb begin
        is_write  = (req_func == fbmon_pkg::FUNC_WRITE_SINGLE);
        param_hit = is_param(reg_num);
        excluded  = (reg_num == fbmon_pkg::fieldbus_node_address_param)
                 || (reg_num == fbmon_pkg::serial_node_address_param)
                 || (reg_num == fbmon_pkg::serial_baud_param)
                 || (reg_num == fbmon_pkg::serial_frame_format_param);
        locked    = drive_running
                 && ((reg_num == fbmon_pkg::command_source_select_param)
                  || (group_of(reg_num) == fbmon_pkg::LOCKED_GROUP));
        use_mem_d = 1'b0;
        exc_d     = fbmon_pkg::EXC_NONE;
        if ((req_func != fbmon_pkg::FUNC_READ_HOLDING) && !is_write) begin
            exc_d = fbmon_pkg::EXC_ILLEGAL_FUNC;
        end else if (mon_hit) begin
            if (is_write) begin
                exc_d = fbmon_pkg::EXC_ILLEGAL_ADDR;
            end
        end else if (param_hit && !excluded) begin
            if (is_write && locked) begin
                exc_d = fbmon_pkg::EXC_DEVICE_FAIL;
            end else if (!is_write) begin
                use_mem_d = 1'b1;
            end
        end else begin
            exc_d = fbmon_pkg::EXC_ILLEGAL_ADDR;
        end
    end

    // ========================================
    // Parameter store
    param_mem_if pmem ();

    // A refused write never reaches the store
    // Values stored as raw 16-bit words
    assign pmem.we    = req_valid && is_write && param_hit && !excluded
                        && (exc_d == fbmon_pkg::EXC_NONE);
    assign pmem.waddr = slot_of(reg_num);
    assign pmem.wdata = req_wdata;
    assign pmem.raddr = slot_of(reg_num);

    // Cleared on reset, so an unwritten parameter reads zero
    param_store u_store (
        .clk   (ref_clk),
        .rst_n (rst_sync_q),
        .ce    (ce),
        .mem   (pmem)
    );

    // ========================================
    // Answer pipeline, fixed two-edge latency so reads and writes line up
    // Trade-off: monitoring reads wait one edge more than they must
    logic        pend_q;
    logic        use_mem_q;
    logic [7:0]  exc_q;
    logic [15:0] data_q;

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pend_q <= 1'b0;
        end else if (ce) begin
            pend_q <= req_valid;
        end
    end

    // Stored words come out of the store's own read register
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            use_mem_q <= 1'b0;
        end else if (ce) begin
            use_mem_q <= use_mem_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            exc_q <= fbmon_pkg::EXC_NONE;
        end else if (ce) begin
            exc_q <= exc_d;
        end
    end

    // Writes echo the word, reads take the measurement
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            data_q <= 16'h0000;
        end else if (ce) begin
            data_q <= is_write ? req_wdata : mon_d;
        end
    end

    // ========================================
    // Answer outputs
    // One-cycle answer strobe
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rsp_valid <= 1'b0;
        end else if (ce) begin
            rsp_valid <= pend_q;
        end
    end

    // Exception code stands as long as the data
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rsp_exc <= fbmon_pkg::EXC_NONE;
        end else if (ce) begin
            rsp_exc <= exc_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rsp_data <= 16'h0000;
        end else if (ce) begin
            if (exc_q != fbmon_pkg::EXC_NONE) begin
                rsp_data <= 16'h0000;
            end else begin
                rsp_data <= use_mem_q ? pmem.rdata : data_q;
            end
        end
    end

endmodule
`default_nettype wire

// file: tb/fbmon_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fbmon_sva (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        req_valid,
    input wire logic [7:0]  req_func,
    input wire logic [15:0] req_addr,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic [7:0]  rsp_exc,
    input wire logic        drive_running,
    input wire logic        standby_active,
    input wire logic [15:0] output_freq_tenths_hz,
    input wire logic [15:0] heatsink_celsius
);
    // ========================================
    // Request to answer relations, clock enable assumed high
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_answer_time; req_valid && ce |-> ##2 rsp_valid; endproperty
    a_answer_time: assert property (p_answer_time) else $error("answer late");
    property p_no_orphan; rsp_valid |-> $past(req_valid, 2); endproperty
    a_no_orphan: assert property (p_no_orphan) else $error("answer without request");
    property p_bad_func;
        req_valid && req_func != 8'h03 && req_func != 8'h06 |-> ##2 rsp_exc == 8'h01;
    endproperty
    a_bad_func: assert property (p_bad_func) else $error("bad function accepted");
    property p_freq;
        req_valid && req_func == 8'h03 && req_addr == 16'h0006
            |-> ##2 rsp_data == $past(output_freq_tenths_hz, 2) && rsp_exc == 8'h00;
    endproperty
    a_freq: assert property (p_freq) else $error("frequency read wrong");
    property p_heat;
        req_valid && req_func == 8'h03 && req_addr == 16'h0017
            |-> ##2 rsp_data == $past(heatsink_celsius, 2);
    endproperty
    a_heat: assert property (p_heat) else $error("heatsink read wrong");
    property p_ro_write;
        req_valid && req_func == 8'h06 && ((req_addr >= 16'h0005 && req_addr <= 16'h000a)
            || (req_addr >= 16'h0013 && req_addr <= 16'h0017)) |-> ##2 rsp_exc == 8'h02;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write taken");
    property p_excluded;
        req_valid && (req_addr == 16'h01f4 || req_addr == 16'h01f6 || req_addr == 16'h01f7
            || req_addr == 16'h0203) |-> ##2 rsp_exc == 8'h02;
    endproperty
    a_excluded: assert property (p_excluded) else $error("excluded parameter reached");
    property p_locked;
        req_valid && req_func == 8'h06 && req_addr == 16'h006f && drive_running
            |-> ##2 rsp_exc == 8'h04;
    endproperty
    a_locked: assert property (p_locked) else $error("locked write taken");
    property p_status;
        rsp_valid && $past(req_func, 2) == 8'h03 && $past(req_addr, 2) == 16'h0005
            |-> !rsp_data[7] && !rsp_data[2] && rsp_data[5] == $past(standby_active, 2);
    endproperty
    a_status: assert property (p_status) else $error("status byte wrong");
endmodule
bind fieldbus_monitor_register_map fbmon_sva chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_exc(rsp_exc),
    .drive_running(drive_running), .standby_active(standby_active),
    .output_freq_tenths_hz(output_freq_tenths_hz), .heatsink_celsius(heatsink_celsius));
`default_nettype wire

// file: tb/fbmon_master.sv
`timescale 1ns/1ps
`default_nettype none
module fbmon_master (
    input  wire logic        clk,
    output var logic         req_valid,
    output var logic [7:0]   req_func,
    output var logic [15:0]  req_addr,
    output var logic [15:0]  req_wdata,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_data,
    input  wire logic [7:0]  rsp_exc
);
    initial begin
        req_valid = 1'b0;
        req_func  = 8'h00;
        req_addr  = 16'h0000;
        req_wdata = 16'h0000;
    end
    // ========================================
    // One request, answer awaited for a bounded span
    task automatic xfer(input logic [7:0] fn, input logic [15:0] num, input logic [15:0] wd,
                        output logic [15:0] rd, output logic [7:0] ex, output bit seen);
        int n;
        seen = 1'b0;
        rd = 16'h0000;
        ex = 8'h00;
        @(posedge clk);
        req_valid <= 1'b1;
        req_func  <= fn;
        req_addr  <= num - 16'h0001;
        req_wdata <= wd;
        @(posedge clk);
        // Released address and data lines carry the inverse so a stale value cannot pass
        req_valid <= 1'b0;
        req_addr  <= ~(num - 16'h0001);
        req_wdata <= ~wd;
        for (n = 0; n < 4 && !seen; n++) begin
            @(posedge clk);
            #1;
            if (rsp_valid === 1'b1) begin
                seen = 1'b1;
                rd = rsp_data;
                ex = rsp_exc;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: tb/fieldbus_monitor_register_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fieldbus_monitor_register_map_tb;
    localparam logic [7:0] rd_f = fbmon_pkg::FUNC_READ_HOLDING;
    localparam logic [7:0] wr_f = fbmon_pkg::FUNC_WRITE_SINGLE;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic run = 1'b0, trip = 1'b0, sto = 1'b0, mnt = 1'b0, stby = 1'b0, mains = 1'b0, en = 1'b0;
    logic [7:0] fcode = 8'h00;
    logic [15:0] meas [10];
    logic req_valid, rsp_valid;
    logic [7:0] req_func, rsp_exc, ex;
    logic [15:0] req_addr, req_wdata, rsp_data, rd, exp_s;
    bit seen;
    int ro_num [10] = '{7, 8, 9, 10, 11, 20, 21, 22, 23, 24};
    int bad_num [6] = '{5, 25, 100, 164, 600, 1};
    int excl_num [4] = '{501, 503, 504, 516};
    int n_mismatch = 0;
    int checks = 0;
    always #2 ref_clk = ~ref_clk;
    initial for (int i = 0; i < 10; i++) meas[i] = 16'h1357 * 16'(i + 1);
    fieldbus_monitor_register_map dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_exc(rsp_exc),
        .drive_running(run), .drive_tripped(trip), .sto_open(sto), .maint_due(mnt),
        .standby_active(stby), .mains_present(mains), .enable_pin(en), .fault_code(fcode),
        .output_freq_tenths_hz(meas[0]), .output_amps_tenths(meas[1]),
        .motor_torque_tenths_pct(meas[2]), .output_kw_hundredths(meas[3]), .din_pins(meas[4]),
        .analog_in_one_level(meas[5]), .analog_in_two_level(meas[6]),
        .unramped_freq_setpoint(meas[7]), .dc_link_volts(meas[8]), .heatsink_celsius(meas[9]));
    fbmon_master mst_u (.clk(ref_clk), .req_valid(req_valid), .req_func(req_func),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_exc(rsp_exc));
    // ========================================
    // Checking helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [7:0] fn, input int num, input logic [15:0] wd,
                       input logic [15:0] ed, input logic [7:0] ee);
        mst_u.xfer(fn, 16'(num), wd, rd, ex, seen);
        chk({15'h0000, seen}, 16'h0001);
        chk(rd, ed);
        chk({8'h00, ex}, {8'h00, ee});
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ========================================
    // Tests
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            acc(rd_f, ro_num[i], 16'h0000, meas[i], 8'h00);
            acc(wr_f, ro_num[i], 16'hffff, 16'h0000, 8'h02);
            acc(rd_f, ro_num[i], 16'h0000, meas[i], 8'h00);
        end
        $display("test measurements done");
        for (int k = 0; k < 128; k++) begin
            @(posedge ref_clk);
            {en, mains, stby, mnt, sto, trip, run} <= k[6:0];
            fcode <= 8'(k) + 8'h40;
            repeat (3) @(posedge ref_clk);
            exp_s = {trip ? fcode : 8'h00, 1'b0, mains & !sto & !trip & en, stby, mnt, sto,
                     1'b0, trip, run};
            acc(rd_f, 6, 16'h0000, exp_s, 8'h00);
        end
        $display("test status done");
        @(posedge ref_clk);
        run <= 1'b0;
        acc(wr_f, 101, 16'd500, 16'd500, 8'h00);
        acc(rd_f, 101, 16'h0000, 16'd500, 8'h00);
        acc(rd_f, 102, 16'h0000, 16'h0000, 8'h00);
        acc(wr_f, 563, 16'habcd, 16'habcd, 8'h00);
        acc(rd_f, 563, 16'h0000, 16'habcd, 8'h00);
        for (int i = 0; i < 6; i++) acc(rd_f, bad_num[i], 16'h0000, 16'h0000, 8'h02);
        for (int i = 0; i < 4; i++) begin
            acc(rd_f, excl_num[i], 16'h0000, 16'h0000, 8'h02);
            acc(wr_f, excl_num[i], 16'h0001, 16'h0000, 8'h02);
        end
        acc(8'h10, 101, 16'h0000, 16'h0000, 8'h01);
        $display("test parameters done");
        acc(wr_f, 112, 16'h0002, 16'h0002, 8'h00);
        @(posedge ref_clk);
        run <= 1'b1;
        acc(wr_f, 112, 16'h0007, 16'h0000, 8'h04);
        acc(wr_f, 563, 16'h0007, 16'h0000, 8'h04);
        acc(rd_f, 112, 16'h0000, 16'h0002, 8'h00);
        acc(rd_f, 563, 16'h0000, 16'habcd, 8'h00);
        acc(wr_f, 113, 16'h0009, 16'h0009, 8'h00);
        $display("test locking done");
        @(posedge ref_clk);
        ce <= 1'b0;
        mst_u.xfer(rd_f, 16'd101, 16'h0000, rd, ex, seen);
        chk({15'h0000, seen}, 16'h0000);
        @(posedge ref_clk);
        ce <= 1'b1;
        acc(rd_f, 112, 16'h0000, 16'h0002, 8'h00);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        acc(rd_f, 101, 16'h0000, 16'h0000, 8'h00);
        acc(rd_f, 563, 16'h0000, 16'h0000, 8'h00);
        $display("test freeze and reset done");
        close_out();
    end
    // Whole run needs about 1100 cycles; ample margin before giving up
    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
